// *** rtl/alu_defs.vh ***
/*
  Shared constants of the data ALU arithmetic extension: operation codes,
  operand select codes, field positions, rounding constants, reset values.
  Assumes it is included by bare name from the design files.
*/
`ifndef ALU_DEFS_VH
`define ALU_DEFS_VH

`define OP_ADD        5'h00
`define OP_SUB        5'h01
`define OP_CMP        5'h02
`define OP_UCMP       5'h03
`define OP_SHL        5'h04
`define OP_SHR        5'h05
`define OP_DPMAC      5'h06
`define OP_IMAC       5'h07
`define OP_SUMAC      5'h08
`define OP_UUMAC      5'h09
`define OP_IMACR      5'h0A
`define OP_MAXS       5'h0B
`define OP_MAXMAG     5'h0C
`define OP_MERGE      5'h0D
`define OP_SUMPY      5'h0E
`define OP_UUMPY      5'h0F
`define OP_IMPY       5'h10
`define OP_IMPYR      5'h11
`define OP_FNORM      5'h12

`define SEL_IN0       3'h0
`define SEL_IN1       3'h1
`define SEL_IN2       3'h2
`define SEL_IN3       3'h3
`define SEL_AMID      3'h4
`define SEL_BMID      3'h5
`define SEL_AFULL     3'h6
`define SEL_BFULL     3'h7

`define MID_HI        47
`define MID_LO        24
`define SHIFT_MAX     6'h37
`define DP_SHIFT      24
`define RND_HALF      56'h00000000800000
`define RND_FRAC_ZERO 24'h000000

`define CCR_C         0
`define CCR_V         1
`define CCR_Z         2
`define CCR_N         3

`define ACC_RST       56'h00000000000000
`define WORD_RST      24'h000000
`define CCR_RST       4'h0

`endif

// *** rtl/alu_mult.v ***
/*
  24 x 24 multiplier with per-operand signedness for the data ALU.
  Purely combinational; the instantiating ALU registers the result.
*/
`timescale 1ns/1ps
`default_nettype none

module alu_mult (
  input  wire        [23:0] mul_a,
  input  wire               a_signed,
  input  wire        [23:0] mul_b,
  input  wire               b_signed,
  output wire signed [48:0] product
);
  wire signed [24:0] a_ext;
  wire signed [24:0] b_ext;
  wire signed [49:0] full;

  // One extra bit per operand lets one signed multiplier serve all mixes
  assign a_ext   = {a_signed & mul_a[23], mul_a};
  assign b_ext   = {b_signed & mul_b[23], mul_b};
  assign full    = a_ext * b_ext;
  assign product = full[48:0];
endmodule

`default_nettype wire

// *** rtl/dsp_data_alu_arith_ext.v ***
/*
  Arithmetic extension of a 24-bit fixed-point data ALU with two 56-bit
  accumulators and four 24-bit input registers. One operation per clock,
  result and condition flags registered.
  Assumes the instruction decoder drives all inputs from the same clock
  and holds rounding mode and sixteen-bit mode from its status register.
// Operation
// - Add takes register, 6-bit short or 24-bit long immediate.
// - Subtract takes register, 6-bit short or 24-bit long immediate.
// - Compare with short or long immediate updates only flags.
// - Multi-bit arithmetic shifts by immediate amount 0 to 55.
// - Shift amount may come from input register or accumulator middle.
// - Unsigned compare subtracts, sets flags, writes no destination.
// - Double-precision MAC adds product to accumulator shifted right 24.
// - Immediate MAC multiplies long immediate by signed register.
// - Mixed MAC multiplies signed by unsigned or unsigned by unsigned.
// - Immediate MAC with round rounds the accumulated result.
// - Signed max copies source when destination minus source <= 0.
// - Magnitude max copies source when magnitude difference <= 0.
// - Merge joins source bits 11-0 with accumulator bits 35-24.
// - Sixteen-bit merge joins 15-8 with 39-32 into bits 47-32.
// - Mixed multiply writes product instead of accumulating.
// - Immediate multiply stores immediate times register product.
// - Immediate multiply with round uses convergent or two's rounding.
// - Fast normalise shifts left on negative, right on positive.
// - Fast normalise can bring leading bit to position 46.
*/
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.vh"

module dsp_data_alu_arith_ext (
  input  wire        clock,
  input  wire        resetn,
  input  wire        op_valid,
  input  wire [4:0]  op_code,
  input  wire        op_negate,
  input  wire [2:0]  src1_sel,
  input  wire [2:0]  src2_sel,
  input  wire        dst_sel,
  input  wire        imm_en,
  input  wire        imm_is_long,
  input  wire [5:0]  imm_short,
  input  wire [23:0] imm_long,
  input  wire        round_twos,
  input  wire        sixteen_bit_mode,
  input  wire        load_valid,
  input  wire [2:0]  load_sel,
  input  wire [55:0] load_data,
  output reg  [55:0] acc_a_q,
  output reg  [55:0] acc_b_q,
  output reg  [3:0]  ccr_q,
  output reg         done_q
);

  reg [23:0] in_reg_q [0:3];
  reg [55:0] result_d;
  reg        write_d;
  reg [3:0]  ccr_d;
  reg [55:0] dst_val;
  reg [55:0] oth_val;
  reg [55:0] sh_src;
  reg [55:0] opnd;
  reg [23:0] word1;
  reg [23:0] word2;
  reg [23:0] imm_word;
  reg [23:0] mul_a;
  reg        a_signed;
  reg        b_signed;
  reg [5:0]  sh_n;
  reg [56:0] sh_wide;
  reg [57:0] sum;
  reg [55:0] prod56;
  reg [55:0] acc_base;
  reg [24:0] norm_mag;
  reg [56:0] mag_d;
  reg [56:0] mag_s;
  wire signed [48:0] product;
  integer i;

  function [23:0] pick_word;
    input [2:0]  sel;
    input [23:0] r0;
    input [23:0] r1;
    input [23:0] r2;
    input [23:0] r3;
    input [55:0] a;
    input [55:0] b;
    begin
      case (sel)
        `SEL_IN0: pick_word = r0;
        `SEL_IN1: pick_word = r1;
        `SEL_IN2: pick_word = r2;
        `SEL_IN3: pick_word = r3;
        `SEL_AMID, `SEL_AFULL: pick_word = a[`MID_HI:`MID_LO];
        default: pick_word = b[`MID_HI:`MID_LO];
      endcase
    end
  endfunction

  // A 24-bit word enters the accumulator format as its middle word
  function [55:0] ext24;
    input [23:0] w;
    begin
      ext24 = {{8{w[23]}}, w, 24'h000000};
    end
  endfunction

  // Returns {overflow, carry or borrow, result}
  function [57:0] addsub;
    input [55:0] a;
    input [55:0] b;
    input        sub;
    reg   [55:0] bb;
    reg   [56:0] s;
    begin
      bb = sub ? ~b : b;
      s = {1'b0, a} + {1'b0, bb} + {56'h00000000000000, sub};
      addsub = {(a[55] == bb[55]) && (s[55] != a[55]),
                sub ? ~s[56] : s[56], s[55:0]};
    end
  endfunction

  // Round at the middle/low boundary; convergent breaks ties to even
  function [55:0] rnd;
    input [55:0] v;
    input        twos;
    reg   [55:0] t;
    begin
      t = v + `RND_HALF;
      if (!twos && t[23:0] == `RND_FRAC_ZERO) begin
        t[24] = 1'b0;
      end
      rnd = {t[55:24], 24'h000000};
    end
  endfunction

  function [56:0] mag;
    input [55:0] v;
    begin
      mag = v[55] ? (57'h0 - {v[55], v}) : {1'b0, v};
    end
  endfunction

  function [3:0] nz_flags;
    input [55:0] v;
    input [3:0]  old;
    begin
      nz_flags = old;
      nz_flags[`CCR_N] = v[55];
      nz_flags[`CCR_Z] = (v == `ACC_RST);
    end
  endfunction

  alu_mult alu_mult_inst (
    .mul_a    (mul_a),
    .a_signed (a_signed),
    .mul_b    (word2),
    .b_signed (b_signed),
    .product  (product)
  );

  always @* begin
    dst_val  = dst_sel ? acc_b_q : acc_a_q;
    oth_val  = dst_sel ? acc_a_q : acc_b_q;
    sh_src   = src2_sel[0] ? acc_b_q : acc_a_q;
    word1    = pick_word(src1_sel, in_reg_q[0], in_reg_q[1], in_reg_q[2],
                         in_reg_q[3], acc_a_q, acc_b_q);
    word2    = pick_word(src2_sel, in_reg_q[0], in_reg_q[1], in_reg_q[2],
                         in_reg_q[3], acc_a_q, acc_b_q);
    imm_word = imm_is_long ? imm_long : {18'h00000, imm_short};
    if (imm_en) begin
      opnd = ext24(imm_word);
    end else if (src1_sel == `SEL_AFULL) begin
      opnd = acc_a_q;
    end else if (src1_sel == `SEL_BFULL) begin
      opnd = acc_b_q;
    end else begin
      opnd = ext24(word1);
    end
    // Immediate multiplies always use the long immediate as first factor
    case (op_code)
      `OP_IMAC, `OP_IMACR, `OP_IMPY, `OP_IMPYR: mul_a = imm_long;
      default: mul_a = word1;
    endcase
    a_signed = (op_code != `OP_UUMAC) && (op_code != `OP_UUMPY);
    b_signed = (op_code != `OP_UUMAC) && (op_code != `OP_UUMPY) &&
               (op_code != `OP_SUMAC) && (op_code != `OP_SUMPY);
    // Fractional product: one left shift drops the duplicate sign bit
    prod56   = {{6{product[48]}}, product, 1'b0};
    // Amounts above 55 are clamped since the accumulator is 56 bits
    sh_n = imm_en ? imm_short : word1[5:0];
    if (sh_n > `SHIFT_MAX) begin
      sh_n = `SHIFT_MAX;
    end
    sh_wide  = 57'h0;
    sum      = 58'h0;
    acc_base = dst_val;
    norm_mag = 25'h0;
    mag_d    = mag(dst_val);
    mag_s    = mag(oth_val);
    result_d = dst_val;
    write_d  = 1'b0;
    ccr_d    = ccr_q;
    if (op_valid) begin
      case (op_code)
        `OP_ADD, `OP_SUB: begin
          sum      = addsub(dst_val, opnd, op_code == `OP_SUB);
          result_d = sum[55:0];
          write_d  = 1'b1;
          ccr_d    = nz_flags(sum[55:0], ccr_q);
          ccr_d[`CCR_V] = sum[57];
          ccr_d[`CCR_C] = sum[56];
        end
        `OP_CMP: begin
          sum   = addsub(dst_val, opnd, 1'b1);
          ccr_d = nz_flags(sum[55:0], ccr_q);
          ccr_d[`CCR_V] = sum[57];
          ccr_d[`CCR_C] = sum[56];
        end
        `OP_UCMP: begin
          // Flags only; no write keeps every destination as it was
          sum   = addsub(dst_val, opnd, 1'b1);
          ccr_d = nz_flags(sum[55:0], ccr_q);
          ccr_d[`CCR_V] = 1'b0;
          ccr_d[`CCR_C] = sum[56];
        end
        `OP_SHL: begin
          sh_wide  = {1'b0, sh_src} << sh_n;
          result_d = sh_wide[55:0];
          write_d  = 1'b1;
          ccr_d    = nz_flags(sh_wide[55:0], ccr_q);
          ccr_d[`CCR_C] = sh_wide[56];
          ccr_d[`CCR_V] = (($signed(sh_wide[55:0]) >>> sh_n) !=
                           $signed(sh_src));
        end
        `OP_SHR: begin
          sh_wide  = $signed({sh_src, 1'b0}) >>> sh_n;
          result_d = sh_wide[56:1];
          write_d  = 1'b1;
          ccr_d    = nz_flags(sh_wide[56:1], ccr_q);
          ccr_d[`CCR_C] = sh_wide[0];
          ccr_d[`CCR_V] = 1'b0;
        end
        `OP_DPMAC, `OP_IMAC, `OP_SUMAC, `OP_UUMAC, `OP_IMACR: begin
          if (op_code == `OP_DPMAC) begin
            acc_base = $signed(dst_val) >>> `DP_SHIFT;
          end
          sum = addsub(acc_base, prod56, op_negate);
          if (op_code == `OP_IMACR) begin
            result_d = rnd(sum[55:0], round_twos);
          end else begin
            result_d = sum[55:0];
          end
          write_d = 1'b1;
          ccr_d   = nz_flags(result_d, ccr_q);
          ccr_d[`CCR_V] = sum[57];
        end
        `OP_SUMPY, `OP_UUMPY, `OP_IMPY, `OP_IMPYR: begin
          sum = addsub(`ACC_RST, prod56, op_negate);
          if (op_code == `OP_IMPYR) begin
            result_d = rnd(sum[55:0], round_twos);
          end else begin
            result_d = sum[55:0];
          end
          write_d = 1'b1;
          ccr_d   = nz_flags(result_d, ccr_q);
          ccr_d[`CCR_V] = 1'b0;
        end
        `OP_MAXS: begin
          // Carry reports that no transfer took place
          write_d = ($signed(dst_val) <= $signed(oth_val));
          result_d = write_d ? oth_val : dst_val;
          ccr_d[`CCR_C] = ~write_d;
        end
        `OP_MAXMAG: begin
          write_d = (mag_d <= mag_s);
          result_d = write_d ? oth_val : dst_val;
          ccr_d[`CCR_C] = ~write_d;
        end
        `OP_MERGE: begin
          result_d = dst_val;
          if (sixteen_bit_mode) begin
            result_d[47:32] = {word1[15:8], dst_val[39:32]};
          end else begin
            result_d[47:24] = {word1[11:0], dst_val[35:24]};
          end
          write_d = 1'b1;
          ccr_d   = nz_flags(result_d, ccr_q);
          ccr_d[`CCR_V] = 1'b0;
        end
        `OP_FNORM: begin
          // Magnitude of the operand is the shift count in either way
          if (word1[23]) begin
            norm_mag = 25'h0 - {word1[23], word1};
            result_d = dst_val << norm_mag;
          end else begin
            result_d = $signed(dst_val) >>> word1;
          end
          write_d = 1'b1;
          ccr_d   = nz_flags(result_d, ccr_q);
          ccr_d[`CCR_V] = 1'b0;
        end
        default: begin
          result_d = dst_val;
          write_d  = 1'b0;
        end
      endcase
    end
  end

  // A load and an operation to the same accumulator: the operation wins
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_a_q <= `ACC_RST;
      acc_b_q <= `ACC_RST;
      ccr_q   <= `CCR_RST;
      done_q  <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        in_reg_q[i] <= `WORD_RST;
      end
    end else begin
      done_q <= op_valid;
      ccr_q  <= ccr_d;
      if (load_valid && load_sel < `SEL_AMID) begin
        in_reg_q[load_sel[1:0]] <= load_data[23:0];
      end
      if (write_d && !dst_sel) begin
        acc_a_q <= result_d;
      end else if (load_valid && load_sel == `SEL_AMID) begin
        acc_a_q <= load_data;
      end
      if (write_d && dst_sel) begin
        acc_b_q <= result_d;
      end else if (load_valid && load_sel == `SEL_BMID) begin
        acc_b_q <= load_data;
      end
    end
  end

endmodule

`default_nettype wire

// *** sim/issue_model.sv ***
/* Decoder-side issue model: drives one ALU operation or one load per call.
   Assumes the ALU samples every input on the rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module issue_model (
  input  wire logic        clock,
  output var  logic        op_valid,
  output var  logic [4:0]  op_code,
  output var  logic        op_negate,
  output var  logic [2:0]  src1_sel,
  output var  logic [2:0]  src2_sel,
  output var  logic        dst_sel,
  output var  logic        imm_en,
  output var  logic        imm_is_long,
  output var  logic [5:0]  imm_short,
  output var  logic [23:0] imm_long,
  output var  logic        round_twos,
  output var  logic        sixteen_bit_mode,
  output var  logic        load_valid,
  output var  logic [2:0]  load_sel,
  output var  logic [55:0] load_data
);
  initial begin
    {op_valid, op_code, op_negate, src1_sel, src2_sel, dst_sel} = '0;
    {imm_en, imm_is_long, imm_short, imm_long, round_twos} = '0;
    {sixteen_bit_mode, load_valid, load_sel, load_data} = '0;
  end

  // Mode bits m are {sixteen-bit mode, two's rounding, negate}
  task automatic op(input [4:0] c, input [2:0] s1, s2, input d, e, l,
                    input [23:0] i, input [2:0] m);
    @(posedge clock);
    {op_valid, op_code, src1_sel, src2_sel, dst_sel} <= {1'b1, c, s1, s2, d};
    {imm_en, imm_is_long, imm_long, imm_short} <= {e, l, i, i[5:0]};
    {sixteen_bit_mode, round_twos, op_negate} <= m;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic ld(input [2:0] s, input [55:0] v);
    @(posedge clock);
    {load_valid, load_sel, load_data} <= {1'b1, s, v};
    @(posedge clock);
    load_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/alu_props.sv ***
/* Port assertions of the data ALU arithmetic extension.
   Assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module alu_props (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        op_valid,
  input wire logic [4:0]  op_code,
  input wire logic [2:0]  src2_sel,
  input wire logic        dst_sel,
  input wire logic        imm_en,
  input wire logic        imm_is_long,
  input wire logic [5:0]  imm_short,
  input wire logic        round_twos,
  input wire logic        sixteen_bit_mode,
  input wire logic        load_valid,
  input wire logic [55:0] acc_a_q,
  input wire logic [55:0] acc_b_q,
  input wire logic        done_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // A load in the same cycle could legally change the other accumulator
  wire go;
  assign go = op_valid && !load_valid;

  a_done_pulse: assert property (op_valid |=> done_q)
    else $error("done pulse missing");
  a_done_cause: assert property (done_q |-> $past(op_valid))
    else $error("done without an operation");
  a_add_short: assert property (
    go && op_code == 5'h00 && imm_en && !imm_is_long && !dst_sel |=>
    acc_a_q == $past(acc_a_q) + {26'h0, $past(imm_short), 24'h0})
    else $error("short immediate add wrong");
  a_cmp_hold: assert property (
    go && op_code == 5'h02 |=> $stable(acc_a_q) && $stable(acc_b_q))
    else $error("compare changed an accumulator");
  a_ucmp_hold: assert property (
    go && op_code == 5'h03 |=> $stable(acc_a_q) && $stable(acc_b_q))
    else $error("unsigned compare changed an accumulator");
  a_shr_imm: assert property (
    go && op_code == 5'h05 && imm_en && !dst_sel && src2_sel[0] &&
    imm_short <= 6'h37 |=> $signed(acc_a_q) ==
    ($signed($past(acc_b_q)) >>> $past(imm_short)))
    else $error("right shift wrong");
  a_max_signed: assert property (
    go && op_code == 5'h0B && !dst_sel |=> acc_a_q ==
    ($signed($past(acc_a_q)) <= $signed($past(acc_b_q)) ?
     $past(acc_b_q) : $past(acc_a_q)))
    else $error("signed max wrong");
  a_merge_norm: assert property (
    go && op_code == 5'h0D && !dst_sel && !sixteen_bit_mode |=>
    acc_a_q[35:0] == $past(acc_a_q[35:0]) &&
    acc_a_q[55:48] == $past(acc_a_q[55:48]))
    else $error("merge touched kept bits");
  a_merge_16: assert property (
    go && op_code == 5'h0D && !dst_sel && sixteen_bit_mode |=>
    acc_a_q[39:0] == $past(acc_a_q[39:0]) &&
    acc_a_q[55:48] == $past(acc_a_q[55:48]))
    else $error("sixteen-bit merge touched kept bits");

  c_fast_norm: cover property (go && op_code == 5'h12);
  c_round: cover property (go && op_code == 5'h11 && round_twos);
  c_max_mag: cover property (go && op_code == 5'h0C);
endmodule

bind dsp_data_alu_arith_ext alu_props alu_props_inst (
  .clock, .resetn, .op_valid, .op_code, .src2_sel, .dst_sel, .imm_en,
  .imm_is_long, .imm_short, .round_twos, .sixteen_bit_mode, .load_valid,
  .acc_a_q, .acc_b_q, .done_q);
`default_nettype wire

// *** sim/test_dsp_data_alu_arith_ext.sv ***
/* Self-checking bench of the data ALU arithmetic extension.
   Assumes issue_model drives every operation and load input. */
`timescale 1ns/1ps
`default_nettype none
module test_dsp_data_alu_arith_ext;
  logic        clock, resetn, op_valid, op_negate, dst_sel, imm_en;
  logic        imm_is_long, round_twos, sixteen_bit_mode, load_valid, done_q;
  logic [4:0]  op_code;
  logic [2:0]  src1_sel, src2_sel, load_sel;
  logic [5:0]  imm_short;
  logic [23:0] imm_long;
  logic [55:0] load_data, acc_a_q, acc_b_q;
  logic [3:0]  ccr_q;
  int          compares = 0;
  int          miscompares = 0;

  issue_model issue_model_inst (.clock, .op_valid, .op_code, .op_negate,
    .src1_sel, .src2_sel, .dst_sel, .imm_en, .imm_is_long, .imm_short,
    .imm_long, .round_twos, .sixteen_bit_mode, .load_valid, .load_sel,
    .load_data);
  dsp_data_alu_arith_ext dsp_data_alu_arith_ext_inst (.clock, .resetn,
    .op_valid, .op_code, .op_negate, .src1_sel, .src2_sel, .dst_sel,
    .imm_en, .imm_is_long, .imm_short, .imm_long, .round_twos,
    .sixteen_bit_mode, .load_valid, .load_sel, .load_data, .acc_a_q,
    .acc_b_q, .ccr_q, .done_q);

  always #2 clock = ~clock;

  // Word as it sits in an accumulator: middle word, sign-extended
  function automatic [55:0] w(input [23:0] x);
    w = {{8{x[23]}}, x, 24'h000000};
  endfunction

  task op(input [4:0] c, input [2:0] s1, s2, input d, e, l,
          input [23:0] i, input [2:0] m);
    issue_model_inst.op(c, s1, s2, d, e, l, i, m);
  endtask

  task ld(input [2:0] s, input [55:0] v);
    issue_model_inst.ld(s, v);
  endtask

  task chk(input [55:0] g, e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task t_arith;
    ld(4, w(24'h100000));
    op(5'h00, 0, 0, 0, 1, 0, 24'h00003F, 0);
    chk(acc_a_q, w(24'h10003F));
    chk(done_q, 1);
    op(5'h02, 0, 0, 0, 1, 1, 24'h10003F, 0);
    chk(ccr_q[2], 1);
    op(5'h01, 0, 0, 0, 1, 1, 24'h800000, 0);
    chk(acc_a_q, 56'h0090003F000000);
    // Register and full-accumulator sources, not only immediates
    ld(0, 56'h000010);
    op(5'h00, 0, 0, 1, 0, 0, 0, 0);
    chk(acc_b_q, w(24'h000010));
    op(5'h01, 6, 0, 1, 0, 0, 0, 0);
    chk(acc_b_q, 56'hFF6FFFD1000000);
    $display("arith done");
  endtask

  task t_shift;
    ld(5, 56'hFF800000000000);
    op(5'h05, 0, 1, 0, 1, 0, 24'h000037, 0);
    chk(acc_a_q, {56{1'b1}});
    ld(1, 56'h4);
    op(5'h04, 1, 1, 0, 0, 0, 0, 0);
    chk(acc_a_q, 56'hF8000000000000);
    $display("shift done");
  endtask

  task t_ucmp;
    ld(4, w(24'h000005));
    ld(0, 56'h5);
    op(5'h03, 0, 0, 0, 0, 0, 0, 0);
    chk(ccr_q[2], 1);
    ld(0, 56'h6);
    op(5'h03, 0, 0, 0, 0, 0, 0, 0);
    chk(ccr_q[0], 1);
    chk(acc_a_q, w(24'h000005));
    $display("ucmp done");
  endtask

  task t_mul;
    ld(0, 56'hFFFFFF);
    ld(1, 56'h2);
    op(5'h0E, 0, 1, 0, 0, 0, 0, 0);
    chk(acc_a_q, 56'hFFFFFFFFFFFFFC);
    op(5'h0F, 0, 1, 1, 0, 0, 0, 0);
    chk(acc_b_q, 56'h3FFFFFC);
    op(5'h09, 0, 1, 1, 0, 0, 0, 0);
    chk(acc_b_q, 56'h7FFFFF8);
    op(5'h08, 0, 1, 1, 0, 0, 0, 1);
    chk(acc_b_q, 56'h7FFFFFC);
    op(5'h10, 1, 1, 0, 0, 0, 24'h400000, 0);
    chk(acc_a_q, 56'h1000000);
    op(5'h07, 1, 1, 0, 0, 0, 24'h400000, 0);
    chk(acc_a_q, 56'h2000000);
    ld(4, 56'hFFFFFFFF000000);
    op(5'h06, 1, 1, 0, 0, 0, 0, 0);
    chk(acc_a_q, 56'h7);
    $display("mul done");
  endtask

  task t_round;
    ld(3, 56'h1);
    ld(4, 56'h0);
    op(5'h0A, 3, 3, 0, 0, 0, 24'h400000, 0);
    chk(acc_a_q, 56'h0);
    op(5'h11, 3, 3, 1, 0, 0, 24'h400000, 3'h2);
    chk(acc_b_q, 56'h1000000);
    op(5'h11, 3, 3, 1, 0, 0, 24'h400000, 0);
    chk(acc_b_q, 56'h0);
    $display("round done");
  endtask

  task t_max;
    ld(4, w(24'hFFFFFD));
    ld(5, w(24'h000002));
    op(5'h0B, 0, 0, 0, 0, 0, 0, 0);
    chk(acc_a_q, w(24'h000002));
    ld(4, w(24'h000007));
    op(5'h0B, 0, 0, 0, 0, 0, 0, 0);
    chk(acc_a_q, w(24'h000007));
    ld(4, w(24'hFFFFF9));
    ld(5, w(24'h000005));
    op(5'h0C, 0, 0, 0, 0, 0, 0, 0);
    chk(acc_a_q, w(24'hFFFFF9));
    ld(4, w(24'hFFFFFD));
    op(5'h0C, 0, 0, 0, 0, 0, 0, 0);
    chk(acc_a_q, w(24'h000005));
    $display("max done");
  endtask

  task t_merge_norm;
    ld(0, 56'hABCDEF);
    ld(4, 56'h123456789ABCDE);
    op(5'h0D, 0, 0, 0, 0, 0, 0, 0);
    chk(acc_a_q, 56'h12DEF6789ABCDE);
    ld(4, 56'h123456789ABCDE);
    op(5'h0D, 0, 0, 0, 0, 0, 0, 3'h4);
    chk(acc_a_q, 56'h12CD56789ABCDE);
    ld(4, 56'h1000000);
    ld(0, 56'hFFFFEA);
    op(5'h12, 0, 0, 0, 0, 0, 0, 0);
    chk(acc_a_q, 56'h400000000000);
    ld(0, 56'h2);
    op(5'h12, 0, 0, 0, 0, 0, 0, 0);
    chk(acc_a_q, 56'h100000000000);
    $display("merge normalise done");
  endtask

  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    t_arith;
    t_shift;
    t_ucmp;
    t_mul;
    t_round;
    t_max;
    t_merge_norm;
    final_report;
  end

  // About 110 cycles of tests; some forty-five times that means a hang
  initial begin
    #20000;
    miscompares++;
    final_report;
  end
endmodule
`default_nettype wire
